// ---- common/sdt_regs.vh ----
`ifndef SDT_REGS_VH
`define SDT_REGS_VH

// ====================================================================
// opcode bytes
`define SDT_OP_ESCAPE 8'h0F
`define SDT_OP_DECIMAL_ADJUST_ADD 8'h27
`define SDT_OP_DECIMAL_ADJUST_SUB 8'h2F
`define SDT_OP_ASCII_ADJUST_DIVIDE 8'hD5
`define SDT_OP_ASCII_DIVIDE_BASE 8'h0A
`define SDT_OP_HALT_INSTR 8'hF4
`define SDT_OP_ADJUST_REQUESTED_PRIVILEGE 8'h63
`define SDT_OP_PFX_LOCK 8'hF0
`define SDT_OP_PFX_ADDR_SIZE 8'h67
`define SDT_OP_PFX_OPND_SIZE 8'h66
`define SDT_OP_PFX_SEG_C 8'h2E
`define SDT_OP_PFX_SEG_D 8'h3E
`define SDT_OP_PFX_SEG_E 8'h26
`define SDT_OP_PFX_SEG_F 8'h64
`define SDT_OP_PFX_SEG_G 8'h65
`define SDT_OP_PFX_SEG_S 8'h36

// ====================================================================
// second opcode bytes after the escape
`define SDT_OP2_TABLE_GROUP_A 8'h00
`define SDT_OP2_TABLE_GROUP_B 8'h01
`define SDT_OP2_LOAD_ACCESS_RIGHTS 8'h02
`define SDT_OP2_LOAD_SEGMENT_LIMIT 8'h03
`define SDT_OP2_CLEAR_TASK_SWITCHED 8'h06
`define SDT_OP2_CACHE_INVALIDATE 8'h08
`define SDT_OP2_CACHE_WRITEBACK_INVALIDATE 8'h09
`define SDT_OP2_MOV_FROM_CTRL 8'h20
`define SDT_OP2_MOV_FROM_DEBUG 8'h21
`define SDT_OP2_MOV_TO_CTRL 8'h22
`define SDT_OP2_MOV_TO_DEBUG 8'h23
`define SDT_OP2_MOV_FROM_TEST 8'h24
`define SDT_OP2_MOV_TO_TEST 8'h26

// ====================================================================
// modrm fields
`define SDT_MOD_REGISTER 2'h3
`define SDT_FLD_0 3'h0
`define SDT_FLD_1 3'h1
`define SDT_FLD_2 3'h2
`define SDT_FLD_3 3'h3
`define SDT_FLD_4 3'h4
`define SDT_FLD_5 3'h5
`define SDT_FLD_6 3'h6
`define SDT_FLD_7 3'h7

// ====================================================================
// instruction classes reported with each completion
`define SDT_CL_UNKNOWN 6'h00
`define SDT_CL_DECIMAL_ADJUST_ADD 6'h01
`define SDT_CL_DECIMAL_ADJUST_SUB 6'h02
`define SDT_CL_ASCII_ADJUST_DIVIDE 6'h03
`define SDT_CL_HALT_INSTR 6'h04
`define SDT_CL_CONTROL_REG_ZERO_WR 6'h05
`define SDT_CL_CTRL_OTHER_WR 6'h06
`define SDT_CL_CTRL_RD 6'h07
`define SDT_CL_DEBUG_WR 6'h08
`define SDT_CL_DEBUG_RD 6'h09
`define SDT_CL_TEST_REG_THREE_WR 6'h0A
`define SDT_CL_TEST_OTHER_WR 6'h0B
`define SDT_CL_TEST_REG_THREE_RD 6'h0C
`define SDT_CL_TEST_OTHER_RD 6'h0D
`define SDT_CL_CLEAR_TASK_SWITCHED 6'h0E
`define SDT_CL_CACHE_INVALIDATE 6'h0F
`define SDT_CL_CACHE_WRITEBACK_INVALIDATE 6'h10
`define SDT_CL_TRANSLATION_ENTRY_INVALIDATE 6'h11
`define SDT_CL_PREFIX 6'h12
`define SDT_CL_ADJUST_REQUESTED_PRIVILEGE 6'h13
`define SDT_CL_LOAD_ACCESS_RIGHTS 6'h14
`define SDT_CL_LOAD_GLOBAL_TABLE 6'h15
`define SDT_CL_LOAD_INTERRUPT_TABLE 6'h16
`define SDT_CL_LOAD_LOCAL_TABLE 6'h17
`define SDT_CL_LOAD_MACHINE_STATUS 6'h18
`define SDT_CL_LOAD_SEGMENT_LIMIT 6'h19
`define SDT_CL_LOAD_TASK_REG 6'h1A
`define SDT_CL_STORE_GLOBAL_TABLE 6'h1B
`define SDT_CL_STORE_INTERRUPT_TABLE 6'h1C
`define SDT_CL_STORE_LOCAL_TABLE 6'h1D
`define SDT_CL_STORE_MACHINE_STATUS 6'h1E
`define SDT_CL_STORE_TASK_REG 6'h1F
`define SDT_CL_VERIFY_READ_ACCESS 6'h20
`define SDT_CL_VERIFY_WRITE_ACCESS 6'h21

// ====================================================================
// clock counts (hit value, then miss penalty)
`define SDT_CLK_ZERO 5'h00
`define SDT_CLK_1 5'h01
`define SDT_CLK_2 5'h02
`define SDT_CLK_3 5'h03
`define SDT_CLK_4 5'h04
`define SDT_CLK_5 5'h05
`define SDT_CLK_6 5'h06
`define SDT_CLK_7 5'h07
`define SDT_CLK_9 5'h09
`define SDT_CLK_10 5'h0A
`define SDT_CLK_11 5'h0B
`define SDT_CLK_12 5'h0C
`define SDT_CLK_13 5'h0D
`define SDT_CLK_14 5'h0E
`define SDT_CLK_16 5'h10
`define SDT_CLK_20 5'h14

`endif

// ---- rtl/sdt_clock_table.v ----
`timescale 1ns/1ns
`default_nettype none
`include "sdt_regs.vh"

module sdt_clock_table (
   // lookup key
   input wire [5:0] opClass,
   input wire memOperand,
   input wire cacheMiss,
   // result
   output reg [4:0] totalClocks
);

   reg [4:0] hitClocks;
   reg [4:0] missPenalty;

   // ====================================================================
   // hit count and miss penalty per class
   always @* begin
      hitClocks = `SDT_CLK_1;
      missPenalty = `SDT_CLK_ZERO;
      case (opClass)
         `SDT_CL_DECIMAL_ADJUST_ADD, `SDT_CL_DECIMAL_ADJUST_SUB: hitClocks = `SDT_CLK_2;
         `SDT_CL_ASCII_ADJUST_DIVIDE: hitClocks = `SDT_CLK_14;
         `SDT_CL_HALT_INSTR: hitClocks = `SDT_CLK_4;
         `SDT_CL_CONTROL_REG_ZERO_WR: begin
            hitClocks = `SDT_CLK_16;
            missPenalty = `SDT_CLK_2;
         end
         `SDT_CL_CTRL_OTHER_WR, `SDT_CL_CTRL_RD: hitClocks = `SDT_CLK_4;
         `SDT_CL_DEBUG_WR: hitClocks = `SDT_CLK_11;
         `SDT_CL_DEBUG_RD: hitClocks = `SDT_CLK_10;
         `SDT_CL_TEST_REG_THREE_WR: hitClocks = `SDT_CLK_6;
         `SDT_CL_TEST_REG_THREE_RD: hitClocks = `SDT_CLK_3;
         `SDT_CL_TEST_OTHER_WR, `SDT_CL_TEST_OTHER_RD: hitClocks = `SDT_CLK_4;
         `SDT_CL_CLEAR_TASK_SWITCHED: begin
            hitClocks = `SDT_CLK_7;
            missPenalty = `SDT_CLK_2;
         end
         `SDT_CL_CACHE_INVALIDATE: hitClocks = `SDT_CLK_4;
         `SDT_CL_CACHE_WRITEBACK_INVALIDATE: hitClocks = `SDT_CLK_5;
         `SDT_CL_PREFIX: hitClocks = `SDT_CLK_1;
         `SDT_CL_ADJUST_REQUESTED_PRIVILEGE: hitClocks = `SDT_CLK_9;
         `SDT_CL_LOAD_ACCESS_RIGHTS: begin
            hitClocks = `SDT_CLK_11;
            missPenalty = memOperand ? `SDT_CLK_5 : `SDT_CLK_3;
         end
         `SDT_CL_LOAD_GLOBAL_TABLE, `SDT_CL_LOAD_INTERRUPT_TABLE: begin
            hitClocks = `SDT_CLK_11;
            missPenalty = `SDT_CLK_5;
         end
         `SDT_CL_LOAD_LOCAL_TABLE: begin
            hitClocks = `SDT_CLK_11;
            missPenalty = memOperand ? `SDT_CLK_6 : `SDT_CLK_3;
         end
         `SDT_CL_LOAD_MACHINE_STATUS: begin
            hitClocks = `SDT_CLK_13;
            missPenalty = memOperand ? `SDT_CLK_1 : `SDT_CLK_ZERO;
         end
         `SDT_CL_LOAD_SEGMENT_LIMIT: begin
            hitClocks = `SDT_CLK_10;
            missPenalty = memOperand ? `SDT_CLK_6 : `SDT_CLK_3;
         end
         `SDT_CL_LOAD_TASK_REG: hitClocks = `SDT_CLK_20;
         `SDT_CL_STORE_GLOBAL_TABLE, `SDT_CL_STORE_INTERRUPT_TABLE: hitClocks = `SDT_CLK_10;
         `SDT_CL_STORE_LOCAL_TABLE, `SDT_CL_STORE_TASK_REG: begin
            hitClocks = memOperand ? `SDT_CLK_3 : `SDT_CLK_2;
         end
         `SDT_CL_STORE_MACHINE_STATUS: begin
            hitClocks = memOperand ? `SDT_CLK_3 : `SDT_CLK_2;
         end
         `SDT_CL_VERIFY_READ_ACCESS, `SDT_CL_VERIFY_WRITE_ACCESS: begin
            hitClocks = `SDT_CLK_11;
            missPenalty = memOperand ? `SDT_CLK_7 : `SDT_CLK_3;
         end
         default: begin
            hitClocks = `SDT_CLK_1;
            missPenalty = `SDT_CLK_ZERO;
         end
      endcase
   end

   // ====================================================================
   // total time; the entry invalidate is the odd one: a miss is faster
   always @* begin
      if (opClass == `SDT_CL_TRANSLATION_ENTRY_INVALIDATE) begin
         totalClocks = cacheMiss ? `SDT_CLK_11 : `SDT_CLK_12;
      end else if (cacheMiss) begin
         totalClocks = hitClocks + missPenalty;
      end else begin
         totalClocks = hitClocks;
      end
   end

endmodule // sdt_clock_table

`default_nettype wire

// ---- rtl/sdt_cycle_counter.v ----
`timescale 1ns/1ns
`default_nettype none
`include "sdt_regs.vh"

module sdt_cycle_counter (
   // clock and reset
   input wire clk,
   input wire srst,
   // load side
   input wire load,
   input wire [4:0] loadValue,
   // status
   output wire busy,
   output wire lastCycle
);

   reg [4:0] count_q;

   // ====================================================================
   // down counter, one count per execution clock
   always @(posedge clk) begin
      if (srst) begin
         count_q <= `SDT_CLK_ZERO;
      end else if (load) begin
         count_q <= loadValue;
      end else if (count_q != `SDT_CLK_ZERO) begin
         count_q <= count_q - `SDT_CLK_1;
      end
   end

   assign busy = (count_q != `SDT_CLK_ZERO);
   assign lastCycle = (count_q == `SDT_CLK_1);

endmodule // sdt_cycle_counter

`default_nettype wire

// ---- rtl/sdt_decoder.v ----
`timescale 1ns/1ns
`default_nettype none
`include "sdt_regs.vh"

module sdt_decoder (
   // clock and reset
   input wire clk,
   input wire srst,
   // instruction byte stream from the prefetcher
   input wire byteValid,
   input wire [7:0] byteData,
   output wire byteReady,
   // operand cache outcome for the instruction being finished
   input wire cacheMiss,
   // completion report
   output wire instrDone,
   output wire busy,
   output reg [5:0] instrClass_q,
   output reg [4:0] instrClocks_q,
   output reg memOperand_q,
   output reg unknownOp_q
);

   // ====================================================================
   // decode states
   localparam [2:0] ST_FIRST = 3'h0;
   localparam [2:0] ST_ESCAPE = 3'h1;
   localparam [2:0] ST_DIVIDE = 3'h2;
   localparam [2:0] ST_MODRM = 3'h3;

   reg [2:0] state_q;
   reg [2:0] state_d;
   reg [7:0] pendOp_q;
   reg [7:0] pendOp_d;
   reg pendEscape_q;
   reg pendEscape_d;
   reg finish;
   reg [5:0] classD;
   reg memD;
   wire take;
   wire [4:0] totalClocks;
   wire [1:0] modField;
   wire [2:0] regField;
   wire isMem;

   // a byte is only taken while no instruction is executing
   assign take = byteValid && byteReady;
   assign byteReady = !busy;
   assign modField = byteData[7:6];
   assign regField = byteData[5:3];
   assign isMem = (modField != `SDT_MOD_REGISTER);

   // ====================================================================
   // byte-by-byte decode
   always @* begin
      state_d = state_q;
      pendOp_d = pendOp_q;
      pendEscape_d = pendEscape_q;
      finish = 1'b0;
      classD = `SDT_CL_UNKNOWN;
      memD = 1'b0;
      if (take) begin
         case (state_q)
            ST_FIRST: begin
               finish = 1'b1;
               case (byteData)
                  `SDT_OP_DECIMAL_ADJUST_ADD: classD = `SDT_CL_DECIMAL_ADJUST_ADD;
                  `SDT_OP_DECIMAL_ADJUST_SUB: classD = `SDT_CL_DECIMAL_ADJUST_SUB;
                  `SDT_OP_HALT_INSTR: classD = `SDT_CL_HALT_INSTR;
                  `SDT_OP_PFX_LOCK, `SDT_OP_PFX_ADDR_SIZE, `SDT_OP_PFX_OPND_SIZE,
                  `SDT_OP_PFX_SEG_C, `SDT_OP_PFX_SEG_D, `SDT_OP_PFX_SEG_E,
                  `SDT_OP_PFX_SEG_F, `SDT_OP_PFX_SEG_G, `SDT_OP_PFX_SEG_S: begin
                     classD = `SDT_CL_PREFIX;
                  end
                  `SDT_OP_ASCII_ADJUST_DIVIDE: begin
                     finish = 1'b0;
                     state_d = ST_DIVIDE;
                  end
                  `SDT_OP_ESCAPE: begin
                     finish = 1'b0;
                     state_d = ST_ESCAPE;
                  end
                  `SDT_OP_ADJUST_REQUESTED_PRIVILEGE: begin
                     finish = 1'b0;
                     pendOp_d = byteData;
                     pendEscape_d = 1'b0;
                     state_d = ST_MODRM;
                  end
                  default: classD = `SDT_CL_UNKNOWN;
               endcase
            end
            ST_DIVIDE: begin
               // any second byte but the base-ten one is not ours
               finish = 1'b1;
               state_d = ST_FIRST;
               if (byteData == `SDT_OP_ASCII_DIVIDE_BASE) begin
                  classD = `SDT_CL_ASCII_ADJUST_DIVIDE;
               end
            end
            ST_ESCAPE: begin
               state_d = ST_FIRST;
               case (byteData)
                  `SDT_OP2_CLEAR_TASK_SWITCHED: begin
                     finish = 1'b1;
                     classD = `SDT_CL_CLEAR_TASK_SWITCHED;
                  end
                  `SDT_OP2_CACHE_INVALIDATE: begin
                     finish = 1'b1;
                     classD = `SDT_CL_CACHE_INVALIDATE;
                  end
                  `SDT_OP2_CACHE_WRITEBACK_INVALIDATE: begin
                     finish = 1'b1;
                     classD = `SDT_CL_CACHE_WRITEBACK_INVALIDATE;
                  end
                  `SDT_OP2_TABLE_GROUP_A, `SDT_OP2_TABLE_GROUP_B,
                  `SDT_OP2_LOAD_ACCESS_RIGHTS, `SDT_OP2_LOAD_SEGMENT_LIMIT,
                  `SDT_OP2_MOV_FROM_CTRL, `SDT_OP2_MOV_FROM_DEBUG,
                  `SDT_OP2_MOV_TO_CTRL, `SDT_OP2_MOV_TO_DEBUG,
                  `SDT_OP2_MOV_FROM_TEST, `SDT_OP2_MOV_TO_TEST: begin
                     // these carry a modrm byte that picks the variant
                     pendOp_d = byteData;
                     pendEscape_d = 1'b1;
                     state_d = ST_MODRM;
                  end
                  default: begin
                     finish = 1'b1;
                     classD = `SDT_CL_UNKNOWN;
                  end
               endcase
            end
            ST_MODRM: begin
               finish = 1'b1;
               state_d = ST_FIRST;
               memD = isMem;
               if (!pendEscape_q) begin
                  classD = `SDT_CL_ADJUST_REQUESTED_PRIVILEGE;
               end else begin
                  case (pendOp_q)
                     `SDT_OP2_MOV_TO_CTRL: begin
                        // moves to and from special registers are register only
                        memD = 1'b0;
                        if (regField == `SDT_FLD_0) begin
                           classD = `SDT_CL_CONTROL_REG_ZERO_WR;
                        end else begin
                           classD = `SDT_CL_CTRL_OTHER_WR;
                        end
                     end
                     `SDT_OP2_MOV_FROM_CTRL: begin
                        memD = 1'b0;
                        classD = `SDT_CL_CTRL_RD;
                     end
                     `SDT_OP2_MOV_TO_DEBUG: begin
                        memD = 1'b0;
                        classD = `SDT_CL_DEBUG_WR;
                     end
                     `SDT_OP2_MOV_FROM_DEBUG: begin
                        memD = 1'b0;
                        classD = `SDT_CL_DEBUG_RD;
                     end
                     `SDT_OP2_MOV_TO_TEST: begin
                        memD = 1'b0;
                        classD = (regField == `SDT_FLD_3) ? `SDT_CL_TEST_REG_THREE_WR :
                           `SDT_CL_TEST_OTHER_WR;
                     end
                     `SDT_OP2_MOV_FROM_TEST: begin
                        memD = 1'b0;
                        classD = (regField == `SDT_FLD_3) ? `SDT_CL_TEST_REG_THREE_RD :
                           `SDT_CL_TEST_OTHER_RD;
                     end
                     `SDT_OP2_LOAD_ACCESS_RIGHTS: classD = `SDT_CL_LOAD_ACCESS_RIGHTS;
                     `SDT_OP2_LOAD_SEGMENT_LIMIT: classD = `SDT_CL_LOAD_SEGMENT_LIMIT;
                     `SDT_OP2_TABLE_GROUP_A: begin
                        case (regField)
                           `SDT_FLD_0: classD = `SDT_CL_STORE_LOCAL_TABLE;
                           `SDT_FLD_1: classD = `SDT_CL_LOAD_TASK_REG;
                           `SDT_FLD_2: classD = `SDT_CL_LOAD_LOCAL_TABLE;
                           `SDT_FLD_3: classD = `SDT_CL_STORE_TASK_REG;
                           `SDT_FLD_4: classD = `SDT_CL_VERIFY_READ_ACCESS;
                           `SDT_FLD_5: classD = `SDT_CL_VERIFY_WRITE_ACCESS;
                           default: classD = `SDT_CL_UNKNOWN;
                        endcase
                     end
                     `SDT_OP2_TABLE_GROUP_B: begin
                        case (regField)
                           `SDT_FLD_0: classD = `SDT_CL_STORE_GLOBAL_TABLE;
                           `SDT_FLD_1: classD = `SDT_CL_STORE_INTERRUPT_TABLE;
                           `SDT_FLD_2: classD = `SDT_CL_LOAD_GLOBAL_TABLE;
                           `SDT_FLD_3: classD = `SDT_CL_LOAD_INTERRUPT_TABLE;
                           `SDT_FLD_4: classD = `SDT_CL_STORE_MACHINE_STATUS;
                           `SDT_FLD_6: classD = `SDT_CL_LOAD_MACHINE_STATUS;
                           `SDT_FLD_7: begin
                              // entry invalidate needs a memory operand
                              classD = isMem ? `SDT_CL_TRANSLATION_ENTRY_INVALIDATE :
                                 `SDT_CL_UNKNOWN;
                           end
                           default: classD = `SDT_CL_UNKNOWN;
                        endcase
                     end
                     default: classD = `SDT_CL_UNKNOWN;
                  endcase
               end
            end
            default: begin
               finish = 1'b0;
               state_d = ST_FIRST;
            end
         endcase
      end
   end

   // ====================================================================
   // timing lookup for the instruction being finished this cycle
   sdt_clock_table uTable (
      .opClass(classD),
      .memOperand(memD),
      .cacheMiss(cacheMiss),
      .totalClocks(totalClocks)
   );

   // execution occupancy; the stream stalls until the count runs out
   sdt_cycle_counter uCounter (
      .clk(clk),
      .srst(srst),
      .load(finish),
      .loadValue(totalClocks),
      .busy(busy),
      .lastCycle(instrDone)
   );

   // ====================================================================
   // decode state and held opcode
   always @(posedge clk) begin
      if (srst) begin
         state_q <= ST_FIRST;
         pendOp_q <= 8'h00;
         pendEscape_q <= 1'b0;
      end else begin
         state_q <= state_d;
         pendOp_q <= pendOp_d;
         pendEscape_q <= pendEscape_d;
      end
   end

   // ====================================================================
   // completion report, captured when the last byte is taken
   always @(posedge clk) begin
      if (srst) begin
         instrClass_q <= `SDT_CL_UNKNOWN;
         instrClocks_q <= `SDT_CLK_ZERO;
         memOperand_q <= 1'b0;
         unknownOp_q <= 1'b0;
      end else if (finish) begin
         instrClass_q <= classD;
         instrClocks_q <= totalClocks;
         memOperand_q <= memD;
         unknownOp_q <= (classD == `SDT_CL_UNKNOWN);
      end
   end

endmodule // sdt_decoder

`default_nettype wire

// ---- test/sdt_decoder_properties.sv ----
`timescale 1ns/1ns
`default_nettype none
module sdt_decoder_props (
   // clock and reset
   input wire clk,
   input wire srst,
   // byte stream
   input wire byteValid,
   input wire [7:0] byteData,
   input wire byteReady,
   input wire cacheMiss,
   // report
   input wire instrDone,
   input wire busy,
   input wire [5:0] instrClass_q,
   input wire [4:0] instrClocks_q,
   input wire memOperand_q,
   input wire unknownOp_q
);
   // ===================================
   // helpers: first-byte tracker, busy length
   logic first_q;
   logic [4:0] busyCnt_q;
   wire take = byteValid && byteReady;
   // a retiring instruction always raises busy, so busy marks the next first byte
   always @(posedge clk) begin
      if (srst || busy) first_q <= 1'b1;
      else if (take) first_q <= 1'b0;
   end
   // counts busy cycles so far; cleared while idle
   always @(posedge clk) begin
      if (srst || !busy) busyCnt_q <= 5'h00;
      else busyCnt_q <= busyCnt_q + 5'h01;
   end
   default clocking cb @(posedge clk); endclocking
   default disable iff (srst);
   // ===================================
   // sequences and properties
   sequence s_first(logic [7:0] b);
      take && first_q && byteData == b;
   endsequence
   sequence s_esc(logic [7:0] b);
      s_first(8'h0F) ##1 take && byteData == b;
   endsequence
   property p_len;
      instrDone |-> busy && busyCnt_q + 5'h01 == instrClocks_q;
   endproperty
   property p_idle;
      instrDone |=> !busy && byteReady;
   endproperty
   property p_stable;
      busy && $past(busy) |-> $stable(instrClocks_q) && $stable(instrClass_q);
   endproperty
   property p_dec_add;
      s_first(8'h27) |=> busy && instrClass_q == 6'h01 && instrClocks_q == 5'h02;
   endproperty
   property p_ascii_div;
      s_first(8'hD5) ##1 take && byteData == 8'h0A |=> instrClocks_q == 5'h0E;
   endproperty
   property p_ctrl_zero;
      s_esc(8'h22) ##1 take && byteData == 8'hC0 && cacheMiss |=> instrClocks_q == 5'h12;
   endproperty
   property p_clr_task_sw;
      s_esc(8'h06) |=> instrClass_q == 6'h0E && instrClocks_q == ($past(cacheMiss) ? 9 : 7);
   endproperty
   property p_wbinv;
      s_esc(8'h09) |=> instrClocks_q == 5'h05 ##4 instrDone;
   endproperty
   property p_pfx;
      s_first(8'hF0) or s_first(8'h67) or s_first(8'h66) |=> instrClocks_q == 5'h01 && instrDone;
   endproperty
   a_len: assert property (p_len) else $error("busy length differs from clocks");
   a_idle: assert property (p_idle) else $error("busy after done");
   a_stable: assert property (p_stable) else $error("report moved while busy");
   a_dec_add: assert property (p_dec_add) else $error("decimal adjust timing");
   a_ascii_div: assert property (p_ascii_div) else $error("ascii divide timing");
   a_ctrl_zero: assert property (p_ctrl_zero) else $error("control zero miss timing");
   a_clr_task_sw: assert property (p_clr_task_sw) else $error("task switched clear timing");
   a_wbinv: assert property (p_wbinv) else $error("write-back invalidate timing");
   a_pfx: assert property (p_pfx) else $error("prefix timing");
endmodule // sdt_decoder_props
bind sdt_decoder sdt_decoder_props i_props (.clk(clk), .srst(srst), .byteValid(byteValid),
   .byteData(byteData), .byteReady(byteReady), .cacheMiss(cacheMiss), .instrDone(instrDone),
   .busy(busy), .instrClass_q(instrClass_q), .instrClocks_q(instrClocks_q),
   .memOperand_q(memOperand_q), .unknownOp_q(unknownOp_q));
`default_nettype wire

// ---- test/test_system_instr_decode_timing.sv ----
`timescale 1ns/1ns
`default_nettype none
module test_system_instr_decode_timing;
   // ===================================
   // stimulus, observation, expected notes
   logic clk, srst, byteValid, cacheMiss, miss;
   logic [7:0] byteData;
   logic [12:0] note;
   logic [7:0] pfx[4] = '{8'hF0, 8'h67, 8'h66, 8'h2E};
   wire byteReady, instrDone, busy, memOperand_q, unknownOp_q;
   wire [5:0] instrClass_q;
   wire [4:0] instrClocks_q;
   int fail_count = 0;
   int samples_checked = 0;
   int seed = 37;
   logic [12:0] notes[$];
   sdt_decoder i_dut (.clk(clk), .srst(srst), .byteValid(byteValid), .byteData(byteData),
      .byteReady(byteReady), .cacheMiss(cacheMiss), .instrDone(instrDone), .busy(busy),
      .instrClass_q(instrClass_q), .instrClocks_q(instrClocks_q),
      .memOperand_q(memOperand_q), .unknownOp_q(unknownOp_q));
   initial begin
      clk = 1'b0;
      forever #5 clk = ~clk;
   end
   task automatic chk(input logic [7:0] seen, exp);
      samples_checked++;
      if (seen !== exp) begin
         fail_count++;
         $display("MISMATCH t=%0t seen %h exp %h", $time, seen, exp);
      end
   endtask
   task automatic finish_test;
      $display("checks %0d mismatches %0d", samples_checked, fail_count);
      if (fail_count == 0 && samples_checked > 0) $display("Result: passed");
      else $display("Result: failed");
      $finish;
   endtask
   // one instruction; valid drops only while busy, so intermediates go back to back
   task automatic op(input logic [7:0] a, b, c, input int n, input logic [5:0] cl,
         input int hit, pen);
      logic [7:0] bs[3];
      logic mem;
      bs = '{a, b, c};
      mem = (n == 3 || a == 8'h63) && bs[n-1][7:6] != 2'h3;
      for (int i = 0; i < n; i++) begin
         @(negedge clk);
         while (!byteReady) begin
            byteValid = 1'b0;
            @(negedge clk);
         end
         byteValid = 1'b1;
         byteData = bs[i];
         cacheMiss = (i == n - 1) ? miss : 1'($random(seed));
      end
      notes.push_back({cl, 5'(hit + (miss ? pen : 0)), mem, cl == 6'h00});
   endtask
   // register form then memory form of one escape instruction
   task automatic pr(input logic [7:0] b, input logic [2:0] f, input logic [5:0] cl,
         input int hr, pr_, hm, pm);
      logic [2:0] r;
      r = 3'($random(seed));
      op(8'h0F, b, {2'b11, f, r}, 3, cl, hr, pr_);
      op(8'h0F, b, {1'b0, 1'($random(seed)), f, r}, 3, cl, hm, pm);
   endtask
   // oldest note against each completion; mid-cycle, clear of the counter's edge
   always @(negedge clk) begin
      if (instrDone === 1'b1) begin
         note = notes.size() ? notes.pop_front() : 13'h1FFF;
         chk(8'(instrClass_q), 8'(note[12:7]));
         chk(8'(instrClocks_q), 8'(note[6:2]));
         chk(8'(memOperand_q), 8'(note[1]));
         chk(8'(unknownOp_q), 8'(note[0]));
      end
   end
   initial begin
      srst = 1'b1;
      byteValid = 1'b0;
      byteData = 8'h00;
      cacheMiss = 1'b0;
      miss = 1'b0;
      repeat (5) @(negedge clk);
      srst = 1'b0;
      for (int p = 0; p < 2; p++) begin
         miss = 1'(p);
         op(8'h27, 8'h00, 8'h00, 1, 6'h01, 2, 0);
         op(8'h2F, 8'h00, 8'h00, 1, 6'h02, 2, 0);
         op(8'hD5, 8'h0A, 8'h00, 2, 6'h03, 14, 0);
         op(8'hD5, 8'h00, 8'h00, 2, 6'h00, 1, 0);
         op(8'h0F, 8'h22, 8'hC0, 3, 6'h05, 16, 2);
         op(8'h0F, 8'h23, 8'hC2, 3, 6'h08, 11, 0);
         op(8'h0F, 8'h21, 8'hFF, 3, 6'h09, 10, 0);
         op(8'h0F, 8'h26, 8'hD8, 3, 6'h0A, 6, 0);
         op(8'h0F, 8'h24, 8'hDA, 3, 6'h0C, 3, 0);
         op(8'h0F, 8'h26, 8'hE0, 3, 6'h0B, 4, 0);
         op(8'h0F, 8'h24, 8'hF1, 3, 6'h0D, 4, 0);
         op(8'h0F, 8'h06, 8'h00, 2, 6'h0E, 7, 2);
         op(8'h0F, 8'h08, 8'h00, 2, 6'h0F, 4, 0);
         op(8'h0F, 8'h09, 8'h00, 2, 6'h10, 5, 0);
         op(8'h0F, 8'h01, 8'h7D, 3, 6'h11, 12, -1);
         foreach (pfx[i]) op(pfx[i], 8'h00, 8'h00, 1, 6'h12, 1, 0);
         op(8'h63, 8'hC3, 8'h00, 2, 6'h13, 9, 0);
         op(8'h63, 8'h1B, 8'h00, 2, 6'h13, 9, 0);
         pr(8'h02, 3'h5, 6'h14, 11, 3, 11, 5);
         op(8'h0F, 8'h01, 8'h10, 3, 6'h15, 11, 5);
         op(8'h0F, 8'h01, 8'h58, 3, 6'h16, 11, 5);
         pr(8'h00, 3'h2, 6'h17, 11, 3, 11, 6);
         pr(8'h01, 3'h6, 6'h18, 13, 0, 13, 1);
         pr(8'h03, 3'h1, 6'h19, 10, 3, 10, 6);
         pr(8'h00, 3'h1, 6'h1A, 20, 0, 20, 0);
         op(8'h0F, 8'h01, 8'h00, 3, 6'h1B, 10, 0);
         op(8'h0F, 8'h01, 8'h48, 3, 6'h1C, 10, 0);
         pr(8'h00, 3'h0, 6'h1D, 2, 0, 3, 0);
         pr(8'h00, 3'h3, 6'h1F, 2, 0, 3, 0);
         pr(8'h01, 3'h4, 6'h1E, 2, 0, 3, 0);
         pr(8'h00, 3'h4, 6'h20, 11, 3, 11, 7);
         pr(8'h00, 3'h5, 6'h21, 11, 3, 11, 7);
         op(8'h0F, 8'hFF, 8'h00, 2, 6'h00, 1, 0);
         op(8'hF4, 8'h00, 8'h00, 1, 6'h04, 4, 0);
         op(8'h0F, 8'h22, 8'hD0, 3, 6'h06, 4, 0);
         op(8'h0F, 8'h20, 8'hC1, 3, 6'h07, 4, 0);
         op(8'h0F, 8'h01, 8'hF8, 3, 6'h00, 1, 0);
         op(8'h0F, 8'h00, 8'h30, 3, 6'h00, 1, 0);
      end
      // drop valid while the last one executes, or its byte is taken again
      @(negedge clk);
      byteValid = 1'b0;
      repeat (30) @(negedge clk);
      chk(8'(notes.size()), 8'h00);
      finish_test();
   end
   // watchdog well beyond the roughly eleven hundred cycles the sequence needs
   initial begin
      #200000;
      fail_count++;
      finish_test();
   end
endmodule // test_system_instr_decode_timing
`default_nettype wire
